// file: src/can_irq_pkg.sv
package can_irq_pkg;

    // ----------------------------------------------------------------
    // Register map (byte offsets, one word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Sources, flag positions and codes
    // ----------------------------------------------------------------
    localparam int NSRC = 9;
    localparam int SRC_IVR = 0;
    localparam int SRC_WAK = 1;
    localparam int SRC_CERR = 2;
    localparam int SRC_SERR = 3;
    localparam int SRC_RBOV = 4;
    localparam int SRC_MOD = 5;
    localparam int SRC_TMR = 6;
    localparam int SRC_RB = 7;
    localparam int SRC_TB = 8;
    // Flag bit of each source; its enable sits EN_SHIFT bits higher
    localparam int FLAG_POS [NSRC] = '{15, 14, 13, 12, 11, 3, 2, 1, 0};
    localparam int EN_SHIFT = 16;
    localparam int CTRL_ON_BIT = 15;
    localparam int FILT_LSB = 8;
    localparam int FILT_W = 5;
    localparam int CODE_W = 7;
    localparam logic [CODE_W-1:0] CODE_IVR = 7'h48;
    localparam logic [CODE_W-1:0] CODE_MOD = 7'h47;
    localparam logic [CODE_W-1:0] CODE_TMR = 7'h46;
    localparam logic [CODE_W-1:0] CODE_SERR_BW = 7'h45;
    localparam logic [CODE_W-1:0] CODE_SERR_ADDR = 7'h44;
    localparam logic [CODE_W-1:0] CODE_RBOV = 7'h43;
    localparam logic [CODE_W-1:0] CODE_WAK = 7'h42;
    localparam logic [CODE_W-1:0] CODE_CERR = 7'h41;
    localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;

    // Bus slave states, Gray along idle -> wait -> last
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD_WAIT = 2'b01,
        ST_RD_LAST = 2'b11,
        ST_WRITE = 2'b10
    } slv_state_t;

endpackage

// file: src/reg_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
// Register access between bus slave and register file
interface reg_bus_if;
    import can_irq_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave_side(output wr_en, output addr, output wdata,
                       input rdata);
    modport regs_side(input wr_en, input addr, input wdata,
                      output rdata);
endinterface
`default_nettype wire

// file: src/ahb_reg_slave.sv
`timescale 1ns/1ns
`default_nettype none
module ahb_reg_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    reg_bus_if.slave_side regs
);
    import can_irq_pkg::*;

    slv_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q;
    logic word_q;
    logic [31:0] hrdata_q;

    // Address phase taken on NONSEQ/SEQ with bus ready
    wire logic take = hsel & htrans[1] & hready;
    wire logic is_word = (hsize == 3'h2);

    // Next state of the transfer sequencer
    always_comb begin
        state_d = ST_IDLE;
        if (state_q == ST_RD_WAIT) begin
            state_d = ST_RD_LAST;
        end else if (take) begin
            state_d = hwrite ? ST_WRITE : ST_RD_WAIT;
        end
    end

    // Sequencer and address latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            addr_q <= '0;
            word_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take) begin
                addr_q <= haddr[ADDR_W-1:0];
                word_q <= is_word;
            end
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (state_q == ST_RD_WAIT) begin
            hrdata_q <= regs.rdata;
        end
    end

    // Outputs; writes of other sizes are ignored
    assign hreadyout = (state_q != ST_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign regs.wr_en = (state_q == ST_WRITE) & word_q;
    assign regs.addr = addr_q;
    assign regs.wdata = hwdata;
endmodule
`default_nettype wire

// file: src/irq_code_encoder.sv
`timescale 1ns/1ns
`default_nettype none
module irq_code_encoder #(
    parameter int FIFO_N = 16
) (
    input wire logic [can_irq_pkg::NSRC-1:0] active,
    input wire logic sys_err_bw,
    input wire logic [FIFO_N-1:0] fifo_active,
    output logic [can_irq_pkg::CODE_W-1:0] code
);
    import can_irq_pkg::*;

    // Fixed priority, highest code wins; FIFO n reports as code n
    always_comb begin
        code = CODE_NONE;
        for (int n = 0; n < FIFO_N; n++) begin
            if (fifo_active[n]) begin
                code = CODE_W'(n);
            end
        end
        if (active[SRC_CERR]) begin
            code = CODE_CERR;
        end
        if (active[SRC_WAK]) begin
            code = CODE_WAK;
        end
        if (active[SRC_RBOV]) begin
            code = CODE_RBOV;
        end
        if (active[SRC_SERR]) begin
            code = sys_err_bw ? CODE_SERR_BW : CODE_SERR_ADDR;
        end
        if (active[SRC_TMR]) begin
            code = CODE_TMR;
        end
        if (active[SRC_MOD]) begin
            code = CODE_MOD;
        end
        if (active[SRC_IVR]) begin
            code = CODE_IVR;
        end
    end
endmodule
`default_nettype wire

// file: src/can_irq_flags.sv
// Overview of operation
// R01 - Nine enable bits gate interrupt requests
// R02 - Invalid message sets flag bit 15
// R03 - Bus wake-up activity sets flag bit 14
// R04 - Bus error sets flag bit 13
// R05 - System fault sets flag bit 12
// R06 - System error clears only by off-on
// R07 - Receive overflow sets flag bit 11
// R08 - Mode reached request sets flag bit 3
// R09 - Timestamp timer overflow sets flag bit 2
// R10 - Bit 1 high while receive buffer pending
// R11 - Bit 0 high while transmit buffer pending
// R12 - Unimplemented bits of both registers read zero
// R13 - Filter hit field reports filters 0 to 15
// R14 - Fixed seven-bit codes for each source but the two buffers
// R15 - System error codes: bandwidth or address
// R16 - FIFO n pending reports code n
// R17 - No pending interrupt reports code 1000000
// R18 - Code reports only enabled sources
// R19 - Software uses bit 15 as module on/off
// R20 - Writing zero clears flag, one leaves it
// R21 - Request output plus highest code first
// R22 - Reset clears enables and flags
`timescale 1ns/1ns
`default_nettype none
module can_irq_flags #(
    parameter int FIFO_N = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Events from the protocol engine, same clock
    input wire logic invalid_msg_evt,
    input wire logic wakeup_evt,
    input wire logic bus_err_evt,
    input wire logic sys_err_evt,
    input wire logic sys_err_is_bw,
    input wire logic rx_overflow_evt,
    input wire logic timer_overflow_evt,
    input wire logic [2:0] current_op_mode,
    input wire logic [2:0] requested_op_mode,
    input wire logic [FIFO_N-1:0] fifo_pending_status,
    input wire logic [FIFO_N-1:0] fifo_is_tx,
    input wire logic filter_hit_valid,
    input wire logic [3:0] filter_hit_num,
    // Results
    output logic irq_req,
    output logic module_on
);
    import can_irq_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (FIFO_N < 1 || FIFO_N > 16) begin : g_bad_fifo_n
        $error("FIFO_N must lie between 1 and 16");
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg_bus_if regs();
    logic [NSRC-1:0] flags_q, flags_d;
    logic [NSRC-1:0] en_q, en_d;
    logic on_q;
    logic sys_bw_q;
    logic [3:0] filt_q;
    logic [CODE_W-1:0] code_q;
    logic [2:0] mode_prev_q;
    logic [NSRC-1:0] evt;
    logic [NSRC-1:0] clr;
    logic [CODE_W-1:0] code_d;

    // Assemble the enable and flag word
    function automatic logic [31:0] pack_flags(input logic [NSRC-1:0] f,
                                               input logic [NSRC-1:0] e);
        logic [31:0] w;
        w = FLAGS_RST;
        for (int i = 0; i < NSRC; i++) begin
            w[FLAG_POS[i]] = f[i];
            w[FLAG_POS[i] + EN_SHIFT] = e[i];
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave and decode
    // ----------------------------------------------------------------
    ahb_reg_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regs(regs)
    );

    // Register selects
    wire logic sel_flags = (regs.addr == OFS_FLAGS);
    wire logic sel_code = (regs.addr == OFS_CODE);
    wire logic sel_ctrl = (regs.addr == OFS_CTRL);
    wire logic wr_flags = regs.wr_en & sel_flags;
    wire logic wr_ctrl = regs.wr_en & sel_ctrl;
    // Module switched back on after being off
    wire logic on_rise = wr_ctrl & regs.wdata[CTRL_ON_BIT] & ~on_q; // [R19]

    // Read words; only defined fields are placed, the rest stays zero
    wire logic [31:0] flags_word = pack_flags(flags_q, en_q); // [R12]
    wire logic [31:0] code_word = {
        {(32 - FILT_LSB - FILT_W){1'b0}}, 1'b0, filt_q, 1'b0, code_q
    }; // [R12] [R13]
    wire logic [31:0] ctrl_word = {
        {(31 - CTRL_ON_BIT){1'b0}}, on_q, {CTRL_ON_BIT{1'b0}}
    };
    assign regs.rdata = sel_flags ? flags_word :
                        sel_code ? code_word :
                        sel_ctrl ? ctrl_word : RDATA_UNMAPPED;

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    // Mode flag: reported mode has just changed to the requested one
    wire logic mode_evt = (current_op_mode != mode_prev_q) &&
                          (current_op_mode == requested_op_mode); // [R08]
    // FIFO pending split by direction
    wire logic [FIFO_N-1:0] rx_pend = fifo_pending_status & ~fifo_is_tx;
    wire logic [FIFO_N-1:0] tx_pend = fifo_pending_status & fifo_is_tx;

    // Event vector in source order
    always_comb begin
        evt = '0;
        evt[SRC_IVR] = invalid_msg_evt; // [R02]
        evt[SRC_WAK] = wakeup_evt; // [R03]
        evt[SRC_CERR] = bus_err_evt; // [R04]
        evt[SRC_SERR] = sys_err_evt; // [R05]
        evt[SRC_RBOV] = rx_overflow_evt; // [R07]
        evt[SRC_MOD] = mode_evt; // [R08]
        evt[SRC_TMR] = timer_overflow_evt; // [R09]
        evt[SRC_RB] = |rx_pend; // [R10]
        evt[SRC_TB] = |tx_pend; // [R11]
    end

    // ----------------------------------------------------------------
    // Flag and enable update
    // ----------------------------------------------------------------
    // Write-zero clears; system error clears only on the off-on step
    always_comb begin
        clr = '0;
        for (int i = 0; i < NSRC; i++) begin
            clr[i] = wr_flags & ~regs.wdata[FLAG_POS[i]]; // [R20]
        end
        clr[SRC_SERR] = on_rise; // [R06]
    end

    // Set wins over clear so no event is lost
    always_comb begin
        flags_d = evt | (flags_q & ~clr);
        en_d = en_q;
        if (wr_flags) begin
            for (int i = 0; i < NSRC; i++) begin
                en_d[i] = regs.wdata[FLAG_POS[i] + EN_SHIFT]; // [R01]
            end
        end
    end

    // Flags, enables and control bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= '0; // [R22]
            en_q <= '0; // [R22]
            on_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            en_q <= en_d;
            if (wr_ctrl) begin
                on_q <= regs.wdata[CTRL_ON_BIT];
            end
        end
    end

    // Side state: system error kind, filter hit, previous mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_bw_q <= 1'b0;
            filt_q <= '0;
            mode_prev_q <= '0;
        end else begin
            if (sys_err_evt) begin
                sys_bw_q <= sys_err_is_bw; // [R15]
            end
            if (filter_hit_valid) begin
                filt_q <= filter_hit_num; // [R13]
            end
            mode_prev_q <= current_op_mode;
        end
    end

    // ----------------------------------------------------------------
    // Code and request
    // ----------------------------------------------------------------
    wire logic [NSRC-1:0] active = flags_q & en_q; // [R18]
    // FIFO reported only when its direction's buffer interrupt is on
    wire logic [FIFO_N-1:0] fifo_active =
        (rx_pend & {FIFO_N{en_q[SRC_RB]}}) |
        (tx_pend & {FIFO_N{en_q[SRC_TB]}}); // [R16] [R18]

    irq_code_encoder #(
        .FIFO_N(FIFO_N)
    ) u_enc (
        .active(active),
        .sys_err_bw(sys_bw_q),
        .fifo_active(fifo_active),
        .code(code_d)
    ); // [R14] [R21]

    // Code register, resets to the idle code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_q <= CODE_NONE; // [R17]
        end else begin
            code_q <= code_d;
        end
    end

    assign irq_req = |active; // [R01] [R21]
    assign module_on = on_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    en_gate_a: assert property (en_q == '0 |-> !irq_req) // [R01]
        else $error("request raised with all enables off");
    ivr_set_a: assert property (invalid_msg_evt |=> flags_q[SRC_IVR]
        && hrdata_flag_ok(SRC_IVR)) // [R02]
        else $error("invalid message flag not set");
    wake_set_a: assert property (wakeup_evt |=> flags_q[SRC_WAK]) // [R03]
        else $error("wake-up flag not set");
    cerr_set_a: assert property (bus_err_evt |=> flags_q[SRC_CERR]) // [R04]
        else $error("bus error flag not set");
    serr_set_a: assert property (sys_err_evt |=> flags_q[SRC_SERR]) // [R05]
        else $error("system error flag not set");
    serr_hold_a: assert property (flags_q[SRC_SERR] && !on_rise
        |=> flags_q[SRC_SERR]) // [R06]
        else $error("system error flag cleared without off-on");
    ovf_set_a: assert property (rx_overflow_evt
        |=> flags_q[SRC_RBOV]) // [R07]
        else $error("receive overflow flag not set");
    mode_set_a: assert property ((current_op_mode != $past(current_op_mode))
        && current_op_mode == requested_op_mode
        |=> flags_q[SRC_MOD]) // [R08]
        else $error("mode change flag not set");
    tmr_set_a: assert property (timer_overflow_evt
        |=> flags_q[SRC_TMR]) // [R09]
        else $error("timer flag not set");
    rb_level_a: assert property ((|rx_pend) |=> flags_q[SRC_RB]) // [R10]
        else $error("receive buffer flag low while pending");
    tb_level_a: assert property ((|tx_pend) |=> flags_q[SRC_TB]) // [R11]
        else $error("transmit buffer flag low while pending");
    unimpl_zero_a: assert property ((flags_word & 32'h07f0_07f0) == '0
        && code_word[31:13] == '0 && !code_word[7]) // [R12] [R13]
        else $error("unimplemented bits read nonzero");
    filt_track_a: assert property (filter_hit_valid
        |=> filt_q == $past(filter_hit_num)) // [R13]
        else $error("filter hit number not captured");
    code_top_a: assert property (active[SRC_IVR]
        |=> code_q == CODE_IVR) // [R14] [R21]
        else $error("invalid message code not reported first");
    serr_code_a: assert property (active == (1 << SRC_SERR)
        |=> code_q[6:1] == CODE_SERR_ADDR[6:1]) // [R15]
        else $error("system error code wrong");
    idle_code_a: assert property (active == '0 && fifo_active == '0
        |=> code_q == CODE_NONE) // [R17]
        else $error("idle code wrong");
    masked_code_a: assert property (active == '0 && fifo_active == '0
        && flags_q != '0 |-> !irq_req ##1 code_q == CODE_NONE) // [R18]
        else $error("masked flag reported");
    wr_clear_a: assert property (wr_flags && !regs.wdata[FLAG_POS[SRC_WAK]]
        && !wakeup_evt |=> !flags_q[SRC_WAK]) // [R20]
        else $error("write of zero did not clear flag");

    // Helper used by an assertion: flag visible in the read word
    function automatic logic hrdata_flag_ok(input int s);
        return flags_word[FLAG_POS[s]] == flags_q[s];
    endfunction

    irq_seen_c: cover property (!irq_req ##1 irq_req);
    serr_clear_c: cover property (flags_q[SRC_SERR] ##1 !flags_q[SRC_SERR]);
    fifo_code_c: cover property (fifo_active != '0 && active == '0
        ##1 code_q < CODE_NONE);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import can_irq_pkg::*;

    // ----------------------------------------------------------------
    // Signals and state
    // ----------------------------------------------------------------
    localparam logic [31:0] EN_ALL = 32'hf80f_0000;
    localparam int LIMIT = 20000;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_req, module_on;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, cur_mode, req_mode;
    logic [5:0] evt;
    logic sys_bw, filt_v;
    logic [15:0] fifo_pend, fifo_tx;
    logic [3:0] filt_num, cur_filt;
    logic [31:0] exp_q[$];
    bit rd_pend;
    int fail_count, compares, cycles;
    int ev_idx[6] = '{0, 1, 2, 4, 5, 6};
    int ev_src[6] = '{SRC_IVR, SRC_WAK, SRC_CERR, SRC_RBOV, SRC_TMR, SRC_MOD};
    logic [6:0] ev_code[6] = '{CODE_IVR, CODE_WAK, CODE_CERR, CODE_RBOV,
                               CODE_TMR, CODE_MOD};

    can_irq_flags #(.FIFO_N(16)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .invalid_msg_evt(evt[0]), .wakeup_evt(evt[1]),
        .bus_err_evt(evt[2]), .sys_err_evt(evt[3]), .sys_err_is_bw(sys_bw),
        .rx_overflow_evt(evt[4]), .timer_overflow_evt(evt[5]),
        .current_op_mode(cur_mode), .requested_op_mode(req_mode),
        .fifo_pending_status(fifo_pend), .fifo_is_tx(fifo_tx),
        .filter_hit_valid(filt_v), .filter_hit_num(filt_num),
        .irq_req(irq_req), .module_on(module_on)
    );

    // Free-running clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [31:0] exp_code(input logic [6:0] c);
        return {19'h0, 1'b0, cur_filt, 1'b0, c};
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Write of one word; the task returns at the edge ending its data phase
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] sz = 3'h2);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // Read of one word; the expected value is noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // One source event; index 6 stands for a completed mode change
    task automatic fire(input int e);
        logic [2:0] m;
        if (e == 6) begin
            m = cur_mode ^ 3'($urandom_range(1, 7));
            req_mode <= m;
            @(posedge hclk);
            cur_mode <= m;
            @(posedge hclk);
        end else begin
            evt[e] <= 1'b1;
            @(posedge hclk);
            evt <= 6'h0;
        end
    endtask

    // Takes read data at the edge that ends each read data phase
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            rd_pend = 1'b0;
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
            rd_pend = 1'b1;
    end

    // Cuts a hung run short
    always @(posedge hclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] p;
        logic [15:0] t;
        logic [6:0] hi;
        logic [31:0] bf;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        evt = 6'h0;
        sys_bw = 1'b0;
        cur_mode = 3'h0;
        req_mode = 3'h0;
        fifo_pend = 16'h0;
        fifo_tx = 16'h0;
        filt_v = 1'b0;
        filt_num = 4'h0;
        cur_filt = 4'h0;
        void'($urandom(32'h1446));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, unmapped place
        rd(OFS_FLAGS, FLAGS_RST);
        rd(OFS_CODE, exp_code(CODE_NONE));
        rd(OFS_CTRL, 32'h0);
        rd(8'h0c, RDATA_UNMAPPED);
        check({31'h0, irq_req}, 32'h0);
        wr(OFS_CTRL, 32'h0000_8000);
        idle(1);
        check({31'h0, module_on}, 32'h1);
        wr(OFS_FLAGS, 32'hffff_ffff);
        rd(OFS_FLAGS, EN_ALL);
        // Six single sources, all but system error and the buffers: flag, code, request, clear
        for (int i = 0; i < 6; i++) begin
            fire(ev_idx[i]);
            idle(2);
            rd(OFS_FLAGS, EN_ALL | (32'h1 << FLAG_POS[ev_src[i]]));
            rd(OFS_CODE, exp_code(ev_code[i]));
            check({31'h0, irq_req}, 32'h1);
            wr(OFS_FLAGS, EN_ALL);
            idle(2);
            check({31'h0, irq_req}, 32'h0);
            rd(OFS_FLAGS, EN_ALL);
            rd(OFS_CODE, exp_code(CODE_NONE));
        end
        // System error: both codes, write-clear refused, off-on clears
        for (int b = 0; b < 2; b++) begin
            sys_bw <= b[0];
            fire(3);
            idle(2);
            rd(OFS_CODE, exp_code(b ? CODE_SERR_BW : CODE_SERR_ADDR));
            wr(OFS_FLAGS, EN_ALL);
            idle(2);
            rd(OFS_FLAGS, EN_ALL | 32'h0000_1000);
            wr(OFS_CTRL, 32'h0);
            wr(OFS_CTRL, 32'h0000_8000);
            idle(2);
            rd(OFS_FLAGS, EN_ALL);
            check({31'h0, module_on}, 32'h1);
        end
        // Disabled source sets its flag but raises nothing
        wr(OFS_FLAGS, 32'h0);
        fire(2);
        idle(2);
        rd(OFS_FLAGS, 32'h0000_2000);
        rd(OFS_CODE, exp_code(CODE_NONE));
        check({31'h0, irq_req}, 32'h0);
        wr(OFS_FLAGS, EN_ALL);
        // Two sources at once: highest code first
        evt <= 6'b000011;
        @(posedge hclk);
        evt <= 6'h0;
        idle(2);
        rd(OFS_CODE, exp_code(CODE_IVR));
        wr(OFS_FLAGS, EN_ALL | 32'h0000_4000);
        idle(2);
        rd(OFS_CODE, exp_code(CODE_WAK));
        wr(OFS_FLAGS, EN_ALL);
        // Refused writes: code register, unmapped, half word
        wr(OFS_CODE, $urandom);
        wr(8'h0c, $urandom);
        wr(OFS_FLAGS, 32'h0, 3'h1);
        rd(OFS_FLAGS, EN_ALL);
        rd(OFS_CODE, exp_code(CODE_NONE));
        // Filter hit numbers, top boundary first
        for (int k = 0; k < 4; k++) begin
            filt_num <= (k == 0) ? 4'hf : 4'($urandom_range(0, 15));
            filt_v <= 1'b1;
            @(posedge hclk);
            filt_v <= 1'b0;
            cur_filt = filt_num;
            idle(2);
            rd(OFS_CODE, exp_code(CODE_NONE));
        end
        // FIFO pending: code of the highest FIFO, sticky buffer flags
        bf = 32'h0;
        for (int k = 0; k < 8; k++) begin
            p = (k == 0) ? 16'h0001 : (k == 1) ? 16'h8000 :
                16'($urandom_range(1, 16'hffff));
            t = 16'($urandom);
            fifo_pend <= p;
            fifo_tx <= t;
            for (int j = 0; j < 16; j++)
                if (p[j]) hi = 7'(j);
            bf = bf | ((p & ~t) != 0 ? 32'h2 : 32'h0);
            bf = bf | ((p & t) != 0 ? 32'h1 : 32'h0);
            idle(3);
            rd(OFS_FLAGS, EN_ALL | bf);
            rd(OFS_CODE, exp_code(hi));
            check({31'h0, irq_req}, 32'h1);
        end
        fifo_pend <= 16'h0;
        idle(2);
        wr(OFS_FLAGS, EN_ALL);
        idle(2);
        rd(OFS_FLAGS, EN_ALL);
        rd(OFS_CODE, exp_code(CODE_NONE));
        idle(2);
        give_verdict();
    end
endmodule
`default_nettype wire
